// >>> core/nsro_defines.svh
// Purpose: named constants of the normalized signal routing output block
// Assumes: Q1.15 unsigned normalized values, 0x8000 stands for 1.0
// Notes: byte offsets are word aligned on the AHB-Lite register bus
`ifndef NSRO_DEFINES_SVH
`define NSRO_DEFINES_SVH

// normalized fixed point
`define NSRO_ONE 16'h8000
`define NSRO_HALF 16'h4000
`define NSRO_FRAC 15

// source select codes
`define NSRO_SEL_NC 4'h0
`define NSRO_SEL_CAN1 4'h1
`define NSRO_SEL_ONE 4'hD
`define NSRO_SEL_ZERO 4'hE

// register byte offsets
`define NSRO_A_CTRL 8'h00
`define NSRO_A_VRNG 8'h20
`define NSRO_A_IRNG 8'h30
`define NSRO_A_CODE 8'h40
`define NSRO_A_IST 8'h60
`define NSRO_A_IEN 8'h64
`define NSRO_A_ICLR 8'h68
`define NSRO_A_STAT 8'h6C
`define NSRO_A_SETP 8'h70

// field positions
`define NSRO_F_INV 8
`define NSRO_F_MODE 16
`define NSRO_F_VALID 8

// reset values and limits, millivolts and microamps
`define NSRO_V_MAX_RST 16'h1388
`define NSRO_V_MIN_RST 16'h0000
`define NSRO_I_MAX_RST 16'h4E20
`define NSRO_I_MIN_RST 16'h0FA0
`define NSRO_V_LIM 16'h2710
`define NSRO_I_LIM 16'h4E20

// interrupt status bits
`define NSRO_IRQ_DIS 4
`define NSRO_IRQ_REJ 5
`define NSRO_IRQ_W 6

`endif

// >>> core/nsro_pkg.sv
// Purpose: types of the normalized signal routing output block
// Assumes: constants come from nsro_defines.svh
// Notes: signal state is one-hot so a bad code is easy to spot
package nsro_pkg;

	typedef enum logic [3:0] {
		NSRO_SIG_VALID = 4'b0001,
		NSRO_SIG_SPECIAL = 4'b0010,
		NSRO_SIG_ERROR = 4'b0100,
		NSRO_SIG_NA = 4'b1000
	} nsro_sig_t;

	typedef struct packed {
		logic valid;
		logic [31:0] code;
		logic [15:0] xn;
	} nsro_res_t;

	typedef struct packed {
		logic act;
		logic wr;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic [4:0][3:0] sel;
		logic [4:0] inv;
		logic [3:0] mode;
		logic [3:0][15:0] vmax;
		logic [3:0][15:0] vmin;
		logic [3:0][15:0] imax;
		logic [3:0][15:0] imin;
		logic [3:0][15:0] setp;
		logic [4:0][31:0] code;
		logic [4:0] valid;
		logic en;
		logic [5:0] ist;
		logic [5:0] ien;
		logic irq;
	} nsro_state_t;

endpackage

// >>> core/nsro_top.sv
// Purpose: signal routing fabric and four analog output setpoint channels
// Assumes: source values come from logic on hclk, no synchroniser needed
// Notes: one clock domain, zero wait state register bus
// Summary of operation
// - each input selects any source or none
// - one source may feed many inputs
// - routing held only at input selectors
// - logical values are normalized to zero..one
// - inputs denormalize with their own min/max
// - discrete input is one at half or more
// - inversion yields one minus normalized value
// - invalid source reads zero, inversion skipped
// - every signal carries a 32-bit state code
// - non-bus blocks report abnormal only as error
// - channel mode voltage or current, voltage default
// - voltage range -10..10 V, default 5/0
// - current range -20..20 mA, default 20/4
// - channel source defaults to same-index bus input
// - channel inversion defaults to not inverted
// - one global enable gates all four channels
// - global enable defaults to constant one
// - global enable has own select and inversion
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "nsro_defines.svh"

module nsro_top import nsro_pkg::*; #(
	parameter int NSRC = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [NSRC-1:0][15:0] src_value,
	input wire logic [NSRC-1:0][3:0] src_state,
	input wire logic [NSRC-1:0][31:0] src_code,
	output logic [3:0][15:0] out_setpoint,
	output logic [3:0] out_current_mode,
	output logic out_enable,
	output logic irq
);

	nsro_state_t q;
	nsro_state_t n;
	nsro_res_t res [5];

	// word index of an address inside a bank, or -1 outside it
	function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base,
		input int cnt);
		int i;
		i = -1;
		if (a[1:0] == 2'b00 && a >= base && int'(a - base) < 4 * cnt) begin
			i = int'(a - base) / 4;
		end
		return i;
	endfunction

	// a source is resolved to value and state code; routing lives here only
	function automatic nsro_res_t resolve(input logic [3:0] s, input logic inv);
		nsro_res_t r;
		logic [15:0] v;
		r.valid = 1'b0;
		r.code = 32'h00000000;
		r.xn = 16'h0000;
		v = 16'h0000;
		if (s == `NSRO_SEL_ONE) begin
			r.valid = 1'b1; // constant one block
			v = `NSRO_ONE;
		end else if (s == `NSRO_SEL_ZERO) begin
			r.valid = 1'b1; // constants never flag an abnormal state
		end else if (s != `NSRO_SEL_NC && int'(s) <= NSRC) begin
			if (src_state[s - 4'h1] == NSRO_SIG_VALID) begin
				r.valid = 1'b1;
				// clip keeps the value inside zero..one
				v = (src_value[s - 4'h1] > `NSRO_ONE) ? `NSRO_ONE : src_value[s - 4'h1];
			end else if (src_state[s - 4'h1] != NSRO_SIG_NA) begin
				r.code = src_code[s - 4'h1]; // special or error code travels on
			end
		end
		// invalid stays zero and is never inverted
		if (r.valid) begin
			r.xn = inv ? (`NSRO_ONE - v) : v;
		end
		return r;
	endfunction

	// value = xn * (max - min) + min, signed millivolts or microamps
	function automatic logic [15:0] denorm(input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] xn);
		logic signed [16:0] span;
		logic signed [16:0] x;
		logic signed [33:0] prod;
		logic signed [17:0] sum;
		span = $signed({hi[15], hi}) - $signed({lo[15], lo});
		x = $signed({1'b0, xn});
		prod = span * x;
		sum = $signed({{2{lo[15]}}, lo}) + 18'(prod >>> `NSRO_FRAC);
		return sum[15:0];
	endfunction

	// range pair check: both within limit and max above min
	function automatic logic range_ok(input logic [15:0] hi, input logic [15:0] lo,
		input logic [15:0] lim);
		return $signed(hi) <= $signed(lim) && $signed(lo) >= -$signed(lim)
			&& $signed(hi) > $signed(lo);
	endfunction

	// one resolver per logical input, four channels plus the global enable
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_res
			// a process, not an assign, so source changes read inside the function wake it
			always_comb begin
				res[g] = resolve(q.sel[g], q.inv[g]);
			end
		end
	endgenerate

	// whole next state
	always_comb begin
		int ci;
		int ri;
		int ai;
		logic [15:0] lo;
		logic [15:0] hi;
		logic [5:0] ev;
		logic [5:0] clr;
		ci = -1;
		ri = -1;
		ai = -1;
		lo = 16'h0000;
		hi = 16'h0000;
		ev = 6'h00;
		clr = 6'h00;
		n = q;

		// enable is a discrete input, one at half scale or above
		n.en = res[4].valid && (res[4].xn >= `NSRO_HALF);
		for (int c = 0; c < 5; c++) begin
			n.code[c] = res[c].code;
			n.valid[c] = res[c].valid;
		end
		for (int c = 0; c < 4; c++) begin
			lo = q.mode[c] ? q.imin[c] : q.vmin[c];
			hi = q.mode[c] ? q.imax[c] : q.vmax[c];
			// zero drive when disabled or fed nothing usable
			if (n.en && res[c].valid) begin
				n.setp[c] = denorm(lo, hi, res[c].xn);
			end else begin
				n.setp[c] = 16'h0000;
			end
			ev[c] = !res[c].valid;
		end
		ev[`NSRO_IRQ_DIS] = !n.en;

		// data phase write of the transfer captured last cycle
		if (q.act && q.wr) begin
			ci = bank_idx(q.addr, `NSRO_A_CTRL, 5);
			ri = bank_idx(q.addr, `NSRO_A_VRNG, 4);
			ai = bank_idx(q.addr, `NSRO_A_IRNG, 4);
			if (ci >= 0) begin
				n.sel[ci] = hwdata[3:0];
				n.inv[ci] = hwdata[`NSRO_F_INV];
				if (ci < 4) begin
					n.mode[ci] = hwdata[`NSRO_F_MODE];
				end
			end
			// bad pairs are refused whole, so max stays above min
			if (ri >= 0) begin
				if (range_ok(hwdata[31:16], hwdata[15:0], `NSRO_V_LIM)) begin
					n.vmax[ri] = hwdata[31:16];
					n.vmin[ri] = hwdata[15:0];
				end else begin
					ev[`NSRO_IRQ_REJ] = 1'b1;
				end
			end
			if (ai >= 0) begin
				if (range_ok(hwdata[31:16], hwdata[15:0], `NSRO_I_LIM)) begin
					n.imax[ai] = hwdata[31:16];
					n.imin[ai] = hwdata[15:0];
				end else begin
					ev[`NSRO_IRQ_REJ] = 1'b1;
				end
			end
			if (q.addr == `NSRO_A_IEN) begin
				n.ien = hwdata[`NSRO_IRQ_W-1:0];
			end
			if (q.addr == `NSRO_A_ICLR) begin
				clr = hwdata[`NSRO_IRQ_W-1:0];
			end
		end

		// a new event beats a clear in the same cycle
		n.ist = (q.ist & ~clr) | ev;
		n.irq = |(n.ist & n.ien);

		// address phase: capture and prepare read data for the data phase
		n.act = hsel && htrans[1] && hready;
		n.wr = hwrite;
		n.addr = haddr[7:0];
		n.rdata = 32'h00000000;
		if (n.act && !hwrite) begin
			ci = bank_idx(haddr[7:0], `NSRO_A_CTRL, 5);
			ri = bank_idx(haddr[7:0], `NSRO_A_VRNG, 4);
			ai = bank_idx(haddr[7:0], `NSRO_A_IRNG, 4);
			if (ci >= 0) begin
				n.rdata[3:0] = q.sel[ci];
				n.rdata[`NSRO_F_INV] = q.inv[ci];
				n.rdata[`NSRO_F_MODE] = (ci < 4) ? q.mode[ci] : 1'b0;
			end
			if (ri >= 0) begin
				n.rdata = {q.vmax[ri], q.vmin[ri]};
			end
			if (ai >= 0) begin
				n.rdata = {q.imax[ai], q.imin[ai]};
			end
			ci = bank_idx(haddr[7:0], `NSRO_A_CODE, 5);
			if (ci >= 0) begin
				n.rdata = q.code[ci];
			end
			ci = bank_idx(haddr[7:0], `NSRO_A_SETP, 4);
			if (ci >= 0) begin
				n.rdata[15:0] = q.setp[ci];
			end
			if (haddr[7:0] == `NSRO_A_IST) begin
				n.rdata[`NSRO_IRQ_W-1:0] = q.ist;
			end
			if (haddr[7:0] == `NSRO_A_IEN) begin
				n.rdata[`NSRO_IRQ_W-1:0] = q.ien;
			end
			if (haddr[7:0] == `NSRO_A_STAT) begin
				n.rdata[0] = q.en;
				n.rdata[`NSRO_F_VALID+4:`NSRO_F_VALID] = q.valid;
			end
		end
	end

	// state register; all defaults here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q.act <= 1'b0;
			q.wr <= 1'b0;
			q.addr <= 8'h00;
			q.rdata <= 32'h00000000;
			for (int c = 0; c < 4; c++) begin
				q.sel[c] <= `NSRO_SEL_CAN1 + 4'(c);
				q.vmax[c] <= `NSRO_V_MAX_RST;
				q.vmin[c] <= `NSRO_V_MIN_RST;
				q.imax[c] <= `NSRO_I_MAX_RST;
				q.imin[c] <= `NSRO_I_MIN_RST;
			end
			q.sel[4] <= `NSRO_SEL_ONE;
			q.inv <= 5'h00;
			q.mode <= 4'h0;
			q.setp <= '0;
			q.code <= '0;
			q.valid <= 5'h00;
			q.en <= 1'b0;
			q.ist <= 6'h00;
			q.ien <= 6'h00;
			q.irq <= 1'b0;
		end else begin
			q <= n;
		end
	end

	// read data, setpoint, mode, enable and irq straight from the state flops
	assign hrdata = q.rdata;
	assign hreadyout = 1'b1; // zero wait states, never stretched
	assign hresp = 1'b0;
	assign out_setpoint = q.setp;
	assign out_current_mode = q.mode;
	assign out_enable = q.en;
	assign irq = q.irq;

endmodule

// >>> testbench/nsro_load_model.sv
// Purpose: load on the four output channels
// Assumes: settles one clock after the setpoint
// Notes: level reads zero while outputs are off
`timescale 1ns/100ps
module nsro_load_model (
	input wire logic hclk,
	input wire logic [3:0][15:0] out_setpoint,
	input wire logic out_enable,
	output logic [3:0][15:0] load_level
);
	// a real load lags the converter, so the level trails by a clock
	always_ff @(posedge hclk) begin
		load_level <= out_enable ? out_setpoint : 64'h0;
	end
endmodule

// >>> testbench/nsro_top_checker.sv
// Purpose: port checks of the routing output block
// Assumes: one clock, reset active low
// Notes: bound into every instance of the top module
`timescale 1ns/100ps
module nsro_top_checker #(
	parameter int NSRC = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [NSRC-1:0][15:0] src_value,
	input wire logic [NSRC-1:0][3:0] src_state,
	input wire logic [3:0][15:0] out_setpoint,
	input wire logic [3:0] out_current_mode,
	input wire logic out_enable
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic req, wr, fresh, chg;
	logic [NSRC*20-1:0] src_d;
	logic [3:0] vbad, ibad;
	assign req = hsel && htrans[1];
	assign wr = req && hwrite;
	assign chg = {src_value, src_state} != src_d;
	// delayed sources, and a flag for the first clock after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fresh <= 1'b1;
			src_d <= '0;
		end else begin
			fresh <= 1'b0;
			src_d <= {src_value, src_state};
		end
	end
	// signed limits per channel
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			vbad[c] = $signed(out_setpoint[c]) > 10000 || $signed(out_setpoint[c]) < -10000;
			ibad[c] = $signed(out_setpoint[c]) > 20000 || $signed(out_setpoint[c]) < -20000;
		end
	end
	en_rst_a: assert property ($rose(hresetn) |=> out_enable)
		else $error("enable not up after reset");
	mode_rst_a: assert property ($rose(hresetn) |-> out_current_mode == 4'h0)
		else $error("mode not voltage after reset");
	dis_zero_a: assert property (!out_enable |-> out_setpoint == 64'h0)
		else $error("setpoint while disabled");
	volt_lim_a: assert property ((vbad & ~out_current_mode & ~$past(out_current_mode)) == 4'h0)
		else $error("voltage out of range");
	cur_lim_a: assert property (ibad == 4'h0)
		else $error("current out of range");
	mode_wr_a: assert property ($changed(out_current_mode) |-> $past(wr, 2) || $past(wr, 3))
		else $error("mode moved without a write");
	quiet_a: assert property ((!req && !chg)[*4] |-> $stable(out_setpoint))
		else $error("setpoint moved on a quiet bus");
	en_why_a: assert property ($changed(out_enable) |-> $past(fresh) || $past(chg) || $past(wr, 3))
		else $error("enable moved without cause");
	cover property (!out_enable);
	cover property (out_current_mode != 4'h0);
	cover property (req && !hwrite);
endmodule
bind nsro_top nsro_top_checker #(.NSRC(NSRC)) i_nsro_top_checker (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .src_value, .src_state, .out_setpoint, .out_current_mode, .out_enable);

// >>> testbench/nsro_top_test.sv
// Purpose: self-checking run of the routing output block
// Assumes: 100 MHz hclk, bus reads queued by the driver
// Notes: the monitor pops the oldest note at each read data phase
`timescale 1ns/100ps
`include "nsro_defines.svh"
module nsro_top_test import nsro_pkg::*; ;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_pend = 0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, lfsr = 32'h00015B83, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hready, hreadyout, hresp, irq, out_enable;
	logic [11:0][15:0] src_value = '0;
	logic [11:0][3:0] src_state = {12{4'h1}};
	logic [11:0][31:0] src_code = '0;
	logic [3:0][15:0] out_setpoint, load_level;
	logic [3:0] out_current_mode;
	logic [31:0] exp_q[$];
	int fail_count = 0, n_compared = 0;
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	nsro_top i_nsro_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_value, .src_state, .src_code,
		.out_setpoint, .out_current_mode, .out_enable, .irq);
	nsro_load_model i_nsro_load_model (.hclk, .out_setpoint, .out_enable, .load_level);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// bounded wait; a slave that never answers ends the run
	task automatic wait_rdy();
		for (int k = 0; k < 16; k++) begin
			@(posedge hclk);
			if (hready === 1'b1) return;
		end
		fail_count++;
		report_and_stop();
	endtask
	// one single word transfer; for a read d is the expected data
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		if (!w) exp_q.push_back(d);
		rd_pend <= !w;
		wait_rdy();
		rd_pend <= 1'b0;
	endtask
	task automatic settle();
		repeat (3) @(posedge hclk);
	endtask
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// floor of the scaled span, as the arithmetic shift does
	function automatic logic [31:0] sp(input int mx, input int mn, input int xn);
		return {16'h0, 16'(mn + (((mx - mn) * xn) >>> 15))};
	endfunction
	// read data monitor
	always @(posedge hclk) begin
		if (rd_pend && hready === 1'b1 && exp_q.size() > 0) check(hrdata, exp_q.pop_front());
	end
	initial begin
		repeat (6) begin
			@(posedge hclk);
			for (int i = 0; i < 12; i++) begin
				lfsr = rnd(lfsr);
				src_value[i] <= {1'b0, lfsr[14:0]};
			end
		end
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 5; i++) bus(0, 8'(4 * i), i < 4 ? i + 1 : 32'hD);
		bus(0, `NSRO_A_VRNG, 32'h13880000);
		bus(0, `NSRO_A_IRNG, 32'h4E200FA0);
		bus(0, 8'hFC, 32'h0);
		check(32'(hresp), 32'h0); // unmapped read still answers OKAY
		for (int i = 0; i < 4; i++) check(32'(load_level[i]), sp(5000, 0, src_value[i]));
		bus(0, `NSRO_A_SETP, sp(5000, 0, src_value[0]));
		bus(1, 8'h04, 32'h101);
		bus(1, 8'h08, 32'h10001);
		settle();
		check(32'(load_level[1]), sp(5000, 0, 32768 - src_value[0]));
		check(32'(load_level[2]), sp(20000, 4000, src_value[0]));
		check(32'(out_current_mode), 32'h4);
		lfsr = rnd(lfsr);
		src_state[0] <= NSRO_SIG_ERROR;
		src_code[0] <= lfsr;
		settle();
		for (int i = 0; i < 3; i++) check(32'(load_level[i]), 32'h0);
		bus(0, `NSRO_A_CODE, lfsr);
		bus(0, `NSRO_A_IST, 32'h7);
		check(32'(irq), 32'h0);
		bus(1, `NSRO_A_IEN, 32'h3F);
		settle();
		check(32'(irq), 32'h1);
		src_state[0] <= NSRO_SIG_VALID;
		bus(1, `NSRO_A_ICLR, 32'h3F);
		settle();
		check(32'(irq), 32'h0);
		bus(1, `NSRO_A_VRNG + 8'hC, 32'h00640064);
		bus(1, `NSRO_A_VRNG + 8'hC, 32'h27110000);
		bus(0, `NSRO_A_VRNG + 8'hC, 32'h13880000);
		bus(0, `NSRO_A_IST, 32'h20);
		bus(1, `NSRO_A_VRNG + 8'hC, 32'h2710D8F0);
		settle();
		check(32'(load_level[3]), sp(10000, -10000, src_value[3]));
		bus(1, 8'h10, 32'hE);
		settle();
		for (int i = 0; i < 4; i++) check(32'(out_setpoint[i]), 32'h0);
		bus(1, 8'h10, 32'h10E);
		settle();
		check(32'(out_enable), 32'h1);
		bus(1, 8'h10, 32'h3);
		for (int i = 0; i < 2; i++) begin
			src_value[2] <= 16'(16'h3FFF + i);
			settle();
			check(32'(out_enable), i);
		end
		bus(1, 8'h0C, 32'h0);
		settle();
		check(32'(load_level[3]), 32'h0);
		report_and_stop();
	end
endmodule
